// ===== hdl/lfcu_consts.svh
// Constants of the ladder flow control unit
// Assumes inclusion by the package, the design module and the bench files
`ifndef LFCU_CONSTS_SVH
`define LFCU_CONSTS_SVH
`define LFCU_STACK_W     9
`define LFCU_SUB_W       6
`define LFCU_PC_W        16
`define LFCU_IDX_W       16
`define LFCU_DEPTH       8
`define LFCU_LVL_W       4
`define LFCU_STEP_W      8
`define LFCU_STACK_ENTRY 9'h001
`endif

// ===== hdl/lfcu_pkg.sv
// Types of the ladder flow control unit
// Assumes the constants header is on the include path
`include "lfcu_consts.svh"
package lfcu_pkg;
   typedef enum logic [3:0] {
      LFCU_OP_NONE, LFCU_OP_CALL, LFCU_OP_CONDITIONAL_RETURN, LFCU_OP_RET, LFCU_OP_FOR,
      LFCU_OP_NEXT, LFCU_OP_SEG_LOAD, LFCU_OP_SEG_END, LFCU_OP_TRANS,
      LFCU_OP_OTHER
   } lfcu_op_t;
   // Decoded instruction from fetch, with its own address
   typedef struct packed {
      logic                     valid;
      lfcu_op_t                 op;
      logic [`LFCU_SUB_W-1:0]   sub_num;
      logic [`LFCU_STEP_W-1:0]  step_num;
      logic [`LFCU_IDX_W-1:0]   initial_val;
      logic [`LFCU_IDX_W-1:0]   final_val;
      logic [`LFCU_PC_W-1:0]    pc;
      logic [`LFCU_PC_W-1:0]    loop_exit_pc;
   } lfcu_instr_t;
   // Redirect order to fetch
   typedef struct packed {
      logic                     branch;
      logic [`LFCU_PC_W-1:0]    target;
   } lfcu_redirect_t;
endpackage

// ===== hdl/lfcu_flow.sv
// Ladder flow control unit: calls, returns, counted loops, step segments
// Assumes fetch presents one decoded instruction a cycle and obeys redirects
// How it works
// - call branches to subroutine 0..63, returns after
// - conditional return leaves only when logic true
// - unconditional return always leaves subroutine
// - calls nest eight deep, recursion allowed
// - call saves stack, enters with one on top
// - return restores stack saved at call
// - accumulators untouched by call or return
// - start above end skips the loop
// - loop end increments index, exits past final
// - loop end forces stack top to one
// - loops nest eight deep, paired ends
// - segment load copies step bit to stacks
// - segment body runs only when step stack set
// - powered transition sets target, clears own step
// - several powered transitions all set together
`include "lfcu_consts.svh"
module lfcu_flow (
   input  wire logic                      ref_clk_i,
   input  wire logic                      reset_n_i,
   input  wire lfcu_pkg::lfcu_instr_t     instr_i,
   input  wire logic [`LFCU_STACK_W-1:0]  lstack_i,
   input  wire logic [`LFCU_PC_W-1:0]     sub_base_i,
   output logic [`LFCU_STACK_W-1:0]       lstack_o,
   output logic                           lstack_load_o,
   output lfcu_pkg::lfcu_redirect_t       redirect_o,
   output logic                           exec_enable_o,
   output logic [`LFCU_IDX_W-1:0]         loop_index_o,
   output logic [(1<<`LFCU_STEP_W)-1:0]   step_bits_o,
   output logic                           nest_error_o
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [`LFCU_STACK_W-1:0] save_stack [`LFCU_DEPTH];
   logic [`LFCU_PC_W-1:0]    ret_pc     [`LFCU_DEPTH];
   logic [`LFCU_IDX_W-1:0]   loop_idx   [`LFCU_DEPTH];
   logic [`LFCU_IDX_W-1:0]   loop_fin   [`LFCU_DEPTH];
   logic [`LFCU_PC_W-1:0]    loop_top   [`LFCU_DEPTH];
   logic [`LFCU_LVL_W-1:0]   call_lvl_reg;
   logic [`LFCU_LVL_W-1:0]   loop_lvl_reg;
   logic [(1<<`LFCU_STEP_W)-1:0] step_reg;
   logic                     seg_active_reg;
   logic                     step_stack_reg;
   logic [`LFCU_STEP_W-1:0]  seg_step_reg;

   // Index increment used by loop end only; loop entry loads the initial value
   function automatic logic [`LFCU_IDX_W-1:0] inc_idx(input logic [`LFCU_IDX_W-1:0] v);
      inc_idx = v + `LFCU_IDX_W'(1);
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire v        = instr_i.valid;
   wire gated    = seg_active_reg && !step_stack_reg;
   wire is_call  = v && !gated && instr_i.op == lfcu_pkg::LFCU_OP_CALL;
   wire is_conditional_return  = v && !gated && instr_i.op == lfcu_pkg::LFCU_OP_CONDITIONAL_RETURN;
   wire is_ret   = v && !gated && instr_i.op == lfcu_pkg::LFCU_OP_RET;
   wire is_for   = v && !gated && instr_i.op == lfcu_pkg::LFCU_OP_FOR;
   wire is_next  = v && !gated && instr_i.op == lfcu_pkg::LFCU_OP_NEXT;
   wire is_load  = v && instr_i.op == lfcu_pkg::LFCU_OP_SEG_LOAD;
   wire is_end   = v && instr_i.op == lfcu_pkg::LFCU_OP_SEG_END;
   wire is_trans = v && !gated && instr_i.op == lfcu_pkg::LFCU_OP_TRANS;
   wire call_full = call_lvl_reg == `LFCU_LVL_W'(`LFCU_DEPTH);
   wire loop_full = loop_lvl_reg == `LFCU_LVL_W'(`LFCU_DEPTH);
   wire do_call  = is_call && !call_full;
   wire do_ret   = (is_ret || (is_conditional_return && lstack_i[0]))
                   && call_lvl_reg != '0;
   wire skip_for = is_for && instr_i.initial_val > instr_i.final_val;
   wire do_for   = is_for && !skip_for && !loop_full;
   wire [`LFCU_LVL_W-1:0] ctop = call_lvl_reg - `LFCU_LVL_W'(1);
   wire [`LFCU_LVL_W-1:0] ltop = loop_lvl_reg - `LFCU_LVL_W'(1);
   wire [2:0] cslot = ctop[2:0];
   wire [2:0] lslot = ltop[2:0];
   wire [2:0] cnew  = call_lvl_reg[2:0];
   wire [2:0] lnew  = loop_lvl_reg[2:0];
   wire have_loop = loop_lvl_reg != '0;
   wire [`LFCU_IDX_W-1:0] nidx = inc_idx(loop_idx[lslot]);
   // Compare before the increment so a final value of all ones cannot wrap
   wire loop_again = is_next && have_loop && loop_idx[lslot] < loop_fin[lslot];
   wire loop_done  = is_next && have_loop && !loop_again;

   // ----------------------------------------------------------------
   // Next values for the outputs
   // ----------------------------------------------------------------
   logic [`LFCU_STACK_W-1:0] lstack_next;
   logic                     lstack_load_next;
   lfcu_pkg::lfcu_redirect_t redirect_next;
   always_comb begin
      lstack_next      = lstack_i;
      lstack_load_next = 1'b0;
      redirect_next    = '0;
      if (do_call) begin
         lstack_next      = `LFCU_STACK_ENTRY;
         lstack_load_next = 1'b1;
         redirect_next    = '{1'b1, sub_base_i + `LFCU_PC_W'(instr_i.sub_num)};
      end else if (do_ret) begin
         lstack_next      = save_stack[cslot];
         lstack_load_next = 1'b1;
         redirect_next    = '{1'b1, ret_pc[cslot]};
      end else if (skip_for || (is_for && loop_full)) begin
         redirect_next    = '{1'b1, instr_i.loop_exit_pc};
      end else if (is_next) begin
         lstack_next      = {lstack_i[`LFCU_STACK_W-1:1], 1'b1};
         lstack_load_next = 1'b1;
         if (loop_again)
            redirect_next = '{1'b1, loop_top[lslot]};
      end else if (is_load) begin
         lstack_next      = {lstack_i[`LFCU_STACK_W-1:1], step_reg[instr_i.step_num]};
         lstack_load_next = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Call stack and loop stack (accumulators never pass here)
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         call_lvl_reg <= '0;
         loop_lvl_reg <= '0;
      end else begin
         if (do_call)
            call_lvl_reg <= call_lvl_reg + `LFCU_LVL_W'(1);
         else if (do_ret)
            call_lvl_reg <= ctop;
         if (do_for)
            loop_lvl_reg <= loop_lvl_reg + `LFCU_LVL_W'(1);
         else if (loop_done)
            loop_lvl_reg <= ltop;
      end
   end

   // Frame contents, written on accepted entries, loop index also on loop_again
   always_ff @(posedge ref_clk_i) begin
      if (do_call) begin
         save_stack[cnew] <= lstack_i;
         ret_pc[cnew]     <= instr_i.pc + `LFCU_PC_W'(1);
      end
      if (do_for) begin
         loop_idx[lnew] <= instr_i.initial_val;
         loop_fin[lnew] <= instr_i.final_val;
         loop_top[lnew] <= instr_i.pc + `LFCU_PC_W'(1);
      end else if (loop_again)
         loop_idx[lslot] <= nidx;
   end

   // ----------------------------------------------------------------
   // Step bits and segment state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         step_reg       <= '0;
         seg_active_reg <= 1'b0;
         step_stack_reg <= 1'b0;
         seg_step_reg   <= '0;
      end else if (is_load) begin
         seg_active_reg <= 1'b1;
         step_stack_reg <= step_reg[instr_i.step_num];
         seg_step_reg   <= instr_i.step_num;
      end else if (is_end) begin
         seg_active_reg <= 1'b0;
      end else if (is_trans && lstack_i[0]) begin
         step_reg[instr_i.step_num] <= 1'b1;
         // Outside a segment there is no own step bit to clear
         if (seg_active_reg && instr_i.step_num != seg_step_reg)
            step_reg[seg_step_reg] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output flops
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lstack_o      <= '0;
         lstack_load_o <= 1'b0;
         redirect_o    <= '0;
         exec_enable_o <= 1'b1;
         loop_index_o  <= '0;
         nest_error_o  <= 1'b0;
      end else begin
         lstack_o      <= lstack_next;
         lstack_load_o <= lstack_load_next;
         redirect_o    <= redirect_next;
         exec_enable_o <= is_load ? step_reg[instr_i.step_num] :
                          is_end ? 1'b1 : exec_enable_o;
         loop_index_o  <= do_for ? instr_i.initial_val : loop_again ? nidx : loop_index_o;
         nest_error_o  <= (is_call && call_full) || (is_for && !skip_for && loop_full);
      end
   end
   assign step_bits_o = step_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_call_entry_stack: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      do_call |=> lstack_o == `LFCU_STACK_ENTRY && redirect_o.branch)
      else $error("call did not enter with fresh stack");
   a_ret_restore: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      do_ret |=> lstack_o == $past(save_stack[cslot]))
      else $error("return did not restore stack");
   a_conditional_return_false_stay: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      is_conditional_return && !lstack_i[0] |=> !redirect_o.branch)
      else $error("false conditional return left");
   a_ret_always: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      is_ret && call_lvl_reg != '0 |=> redirect_o.branch)
      else $error("return did not branch");
   a_loop_skip: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      skip_for |=> redirect_o.target == $past(instr_i.loop_exit_pc))
      else $error("empty loop not skipped");
   a_next_top_one: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      is_next |=> lstack_o[0] && lstack_load_o)
      else $error("loop end did not force top");
   a_nest_error: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      is_call && call_full |=> nest_error_o && $stable(call_lvl_reg))
      else $error("ninth call not refused");
   a_depth_bound: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      call_lvl_reg <= `LFCU_LVL_W'(`LFCU_DEPTH) &&
      loop_lvl_reg <= `LFCU_LVL_W'(`LFCU_DEPTH))
      else $error("nesting depth exceeded");
   a_trans_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      is_trans && lstack_i[0] |=> step_reg[$past(instr_i.step_num)])
      else $error("transition target not set");
   c_call_ret: cover property (@(posedge ref_clk_i) do_call ##[1:20] do_ret);
   c_loop_again: cover property (@(posedge ref_clk_i) loop_again);
   c_nest_full: cover property (@(posedge ref_clk_i) is_call && call_full);
   c_trans: cover property (@(posedge ref_clk_i) is_trans && lstack_i[0]);
endmodule

// ===== tb/lfcu_fetch_model.sv
// Fetch-side logic stack model for the flow unit bench
// Assumes the unit's stack load pulse stands for exactly one cycle
`include "lfcu_consts.svh"
module lfcu_fetch_model (
   input  wire logic                     ref_clk_i,
   input  wire logic                     reset_n_i,
   input  wire logic                     eval_en_i,
   input  wire logic [`LFCU_STACK_W-1:0] eval_val_i,
   input  wire logic [`LFCU_STACK_W-1:0] new_stack_i,
   input  wire logic                     load_i,
   output logic      [`LFCU_STACK_W-1:0] lstack_o
);
   // Ladder evaluation writes the stack, the unit's reload wins
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) lstack_o <= 9'h000;
      else if (load_i) lstack_o <= new_stack_i;
      else if (eval_en_i) lstack_o <= eval_val_i;
   end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the ladder flow control unit
// Assumes one instruction a cycle, outputs one cycle after taking
`include "lfcu_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, reset_n_i, eval_en, lsl;
   logic [8:0] eval_val, lsi, lso, sv [8];
   logic [15:0] base, li;
   logic [255:0] sb;
   logic ee, ne;
   lfcu_pkg::lfcu_instr_t in;
   lfcu_pkg::lfcu_redirect_t rd;
   logic [31:0] rng;
   int mismatches, total_checks, cycles;
   lfcu_flow u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .instr_i(in),
      .lstack_i(lsi), .sub_base_i(base), .lstack_o(lso), .lstack_load_o(lsl),
      .redirect_o(rd), .exec_enable_o(ee), .loop_index_o(li), .step_bits_o(sb),
      .nest_error_o(ne));
   lfcu_fetch_model u_fetch (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .eval_en_i(eval_en), .eval_val_i(eval_val), .new_stack_i(lso),
      .load_i(lsl), .lstack_o(lsi));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Drops valid, lets a pending stack reload land, then evaluates a new stack
   task automatic setstk(input logic [8:0] v);
      in.valid = 1'b0;
      @(negedge ref_clk_i);
      eval_en = 1'b1;
      eval_val = v;
      @(negedge ref_clk_i);
      eval_en = 1'b0;
   endtask
   // One instruction taken at the next edge, outputs seen one cycle later;
   // valid stays up until the next instruction or the next stack setup
   task automatic issue(input lfcu_pkg::lfcu_op_t op, input logic [15:0] a, b,
         pc, ex);
      in = '{1'b1, op, a[5:0], a[7:0], a, b, pc, ex};
      @(negedge ref_clk_i);
   endtask
   task automatic br(input logic b, input logic [15:0] t);
      chk("branch", {31'h0, b}, {31'h0, rd.branch});
      if (b) chk("target", {16'h0, t}, {16'h0, rd.target});
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Clock and time limit
   // ----------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles >= 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      reset_n_i = 1'b0;
      eval_en = 1'b0;
      eval_val = 9'h000;
      in = '0;
      rng = 32'h25;
      base = 16'h1000;
      repeat (10) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      chk("exec_rst", 32'h1, {31'h0, ee});
      // Eight nested calls, then a refused ninth
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         sv[i] = rng[8:0];
         setstk(sv[i]);
         issue(lfcu_pkg::LFCU_OP_CALL, {10'h0, rng[14:9]}, 0, 16'(16'h100 + i), 0);
         br(1'b1, base + rng[14:9]);
         chk("call_stack", 32'h1, {23'h0, lso});
         chk("call_load", 32'h1, {31'h0, lsl});
      end
      issue(lfcu_pkg::LFCU_OP_CALL, 16'h3F, 0, 16'h200, 0);
      chk("nest_err", 32'h1, {31'h0, ne});
      br(1'b0, 0);
      // Conditional return held by a false top, then taken
      setstk(9'h1FE);
      issue(lfcu_pkg::LFCU_OP_CONDITIONAL_RETURN, 0, 0, 16'h300, 0);
      br(1'b0, 0);
      setstk(9'h001);
      issue(lfcu_pkg::LFCU_OP_CONDITIONAL_RETURN, 0, 0, 16'h300, 0);
      br(1'b1, 16'h108);
      chk("conditional_return_stack", {23'h0, sv[7]}, {23'h0, lso});
      for (int i = 6; i >= 0; i--) begin
         setstk(9'h000);
         issue(lfcu_pkg::LFCU_OP_RET, 0, 0, 16'h300, 0);
         br(1'b1, 16'(16'h101 + i));
         chk("ret_stack", {23'h0, sv[i]}, {23'h0, lso});
      end
      // Loops: skipped, counted, nested past the limit
      issue(lfcu_pkg::LFCU_OP_FOR, 16'h5, 16'h4, 16'h400, 16'h480);
      br(1'b1, 16'h480);
      issue(lfcu_pkg::LFCU_OP_FOR, 16'h1, 16'h3, 16'h400, 16'h480);
      chk("index", 32'h1, {16'h0, li});
      for (int k = 2; k <= 4; k++) begin
         setstk(9'h0);
         issue(lfcu_pkg::LFCU_OP_NEXT, 0, 0, 16'h410, 0);
         br(k <= 3, 16'h401);
         chk("next_top", 32'h1, {31'h0, lso[0]});
      end
      for (int i = 0; i < 9; i++)
         issue(lfcu_pkg::LFCU_OP_FOR, 16'h0, 16'h0, 16'h500, 16'h580);
      chk("loop_err", 32'h1, {31'h0, ne});
      br(1'b1, 16'h580);
      for (int i = 0; i < 8; i++) begin
         issue(lfcu_pkg::LFCU_OP_NEXT, 0, 0, 16'h510, 0);
         br(1'b0, 0);
      end
      // Step segments and transitions
      setstk(9'h1A5);
      issue(lfcu_pkg::LFCU_OP_SEG_LOAD, 16'h0, 0, 0, 0);
      chk("seg_stack", 32'h1A4, {23'h0, lso});
      chk("exec_off", 32'h0, {31'h0, ee});
      setstk(9'h001);
      issue(lfcu_pkg::LFCU_OP_TRANS, 16'h3, 0, 0, 0);
      chk("gated", 32'h0, sb[31:0]);
      issue(lfcu_pkg::LFCU_OP_SEG_END, 0, 0, 0, 0);
      chk("exec_on", 32'h1, {31'h0, ee});
      issue(lfcu_pkg::LFCU_OP_TRANS, 16'h5, 0, 0, 0);
      issue(lfcu_pkg::LFCU_OP_SEG_LOAD, 16'h5, 0, 0, 0);
      chk("seg_live", 32'h1, {31'h0, ee});
      issue(lfcu_pkg::LFCU_OP_TRANS, 16'h7, 0, 0, 0);
      issue(lfcu_pkg::LFCU_OP_TRANS, 16'h9, 0, 0, 0);
      chk("steps", 32'h280, sb[31:0]);
      issue(lfcu_pkg::LFCU_OP_SEG_END, 0, 0, 0, 0);
      chk("steps_end", 32'h280, sb[31:0]);
      report_and_stop();
   end
endmodule
